/* File: hdl/level_ctrl_pkg.sv */
// Package with register map, reset values, timing constants and types of the level control block.
package level_ctrl_pkg;

   localparam logic [6:0] OFS_LEFT_GAIN    = 7'h0E;
   localparam logic [6:0] OFS_RIGHT_GAIN   = 7'h0F;
   localparam logic [6:0] OFS_TARGET_CEIL  = 7'h10;
   localparam logic [6:0] OFS_HOLD_ENABLE  = 7'h11;
   localparam logic [6:0] OFS_ATTACK_DECAY = 7'h12;
   localparam logic [6:0] OFS_NOISE_GATE   = 7'h13;
   localparam logic [6:0] OFS_LIMITER      = 7'h14;
   localparam logic [6:0] OFS_INPUT_MUTE   = 7'h15;
   localparam logic [6:0] OFS_SOFT_RESET   = 7'h17;

   localparam logic [8:0] RST_GAIN         = 9'h0CF;
   localparam logic [8:0] RST_TARGET_CEIL  = 9'h07B;
   localparam logic [8:0] RST_HOLD_ENABLE  = 9'h000;
   localparam logic [8:0] RST_ATTACK_DECAY = 9'h032;
   localparam logic [8:0] RST_NOISE_GATE   = 9'h000;
   localparam logic [8:0] RST_LIMITER      = 9'h026;
   localparam logic [8:0] RST_INPUT_MUTE   = 9'h001;

   localparam int BIT_ZERO_CROSS  = 7;
   localparam int BIT_GAIN_ENABLE = 8;
   localparam int BIT_GATE_ENABLE = 0;
   localparam int BIT_RIGHT_MUTE  = 6;
   localparam int BIT_LEFT_MUTE   = 7;
   localparam int BIT_LINKED_GAIN = 8;

   localparam logic [1:0] MODE_LIMITER = 2'h0;
   localparam logic [1:0] MODE_RIGHT   = 2'h1;
   localparam logic [1:0] MODE_LEFT    = 2'h2;
   localparam logic [1:0] MODE_STEREO  = 2'h3;

   localparam logic [7:0]        GAIN_ZERO_DB   = 8'hCF;
   localparam logic signed [7:0] TARGET_BASE_DB = -8'sd16;
   localparam logic signed [7:0] GATE_BASE_DB   = -8'sd78;
   localparam logic [3:0]        TIME_SAT_CODE  = 4'hA;
   localparam logic [4:0]        FRAME_BITS     = 5'h10;

   localparam int CLK_PERIOD_NS       = 25;
   localparam int HOLD_BASE_NS        = 2670000;
   localparam int ATK_AUTO_BASE_NS    = 8400000;
   localparam int ATK_LIMIT_BASE_NS   = 250000;
   localparam int DCY_AUTO_BASE_NS    = 33500000;
   localparam int DCY_LIMIT_BASE_NS   = 1200000;
   localparam int WINDOW_BASE_NS      = 62500;
   localparam int HOLD_BASE_CYC       = (HOLD_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ATK_AUTO_BASE_CYC   = (ATK_AUTO_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ATK_LIMIT_BASE_CYC  = (ATK_LIMIT_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DCY_AUTO_BASE_CYC   = (DCY_AUTO_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DCY_LIMIT_BASE_CYC  = (DCY_LIMIT_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [31:0] WINDOW_BASE_CYC = 32'((WINDOW_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [2:0] {PH_IDLE, PH_WINDOW, PH_ATTACK, PH_HOLD, PH_DECAY} phase_e;

   typedef struct packed {
      logic [8:0] left_gain;
      logic [8:0] right_gain;
      logic [8:0] target_ceil;
      logic [8:0] hold_enable;
      logic [8:0] attack_decay;
      logic [8:0] noise_gate;
      logic [8:0] limiter;
      logic [8:0] input_mute;
   } regs_s;

   localparam regs_s REGS_RST = '{RST_GAIN, RST_GAIN, RST_TARGET_CEIL, RST_HOLD_ENABLE,
                                  RST_ATTACK_DECAY, RST_NOISE_GATE, RST_LIMITER, RST_INPUT_MUTE};

   typedef struct packed {
      logic signed [7:0] level_db;
      logic              zero_cross;
   } chan_in_s;

   typedef struct packed {
      logic [1:0] engine_active;
      phase_e     left_phase;
      phase_e     right_phase;
   } status_s;

endpackage

/* File: hdl/adc_level_control_regs.sv */
// Control registers, serial write port and gain engine of the audio input level control.
`timescale 1ns/1ps
module adc_level_control_regs
   import level_ctrl_pkg::*;
#(
   parameter int unsigned HOLD_CYC      = HOLD_BASE_CYC,
   parameter int unsigned ATK_AUTO_CYC  = ATK_AUTO_BASE_CYC,
   parameter int unsigned ATK_LIMIT_CYC = ATK_LIMIT_BASE_CYC,
   parameter int unsigned DCY_AUTO_CYC  = DCY_AUTO_BASE_CYC,
   parameter int unsigned DCY_LIMIT_CYC = DCY_LIMIT_BASE_CYC
) (
   input  wire logic           clk_sys,
   input  wire logic           srst,
   input  wire logic           ctl_clk,
   input  wire logic           ctl_data,
   input  wire logic           ctl_latch,
   input  chan_in_s            left_in,
   input  chan_in_s            right_in,
   output logic [7:0]          left_gain_value,
   output logic [7:0]          right_gain_value,
   output logic                left_channel_mute,
   output logic                right_channel_mute,
   output logic [3:0]          input_pair_select,
   output status_s             engine_status
);

   typedef struct packed {
      regs_s            regs;
      logic [15:0]      shift;
      logic [4:0]       nbits;
      logic             clk_d;
      logic             latch_d;
      logic [1:0][7:0]  gain;
      logic [1:0][31:0] timer;
      phase_e [1:0]     phase;
   } state_s;

   state_s s_r;
   state_s s_nxt;

   logic              commit;
   logic [6:0]        wr_addr;
   logic [8:0]        wr_data;
   logic [1:0]        active;
   logic              auto_mode;
   logic [1:0][7:0]   ceil_g;
   logic [1:0][7:0]   floor_g;
   logic [1:0]        gated;
   logic [1:0]        above;
   logic [1:0][7:0]   static_g;
   chan_in_s [1:0]    cin;
   // Engine terms live at module level so that the checks below can see them.
   logic [1:0]        mode;
   logic [3:0]        att;
   logic [7:0]        att2;
   logic [2:0]        cc;
   logic [3:0]        fc;
   logic [31:0]       hold_c;
   logic [31:0]       atk_c;
   logic [31:0]       dcy_c;
   logic [31:0]       win_c;
   logic signed [7:0] tgt;
   logic signed [7:0] thr;
   logic              step_ok;

   function automatic logic [31:0] scaled(input logic [31:0] base, input logic [3:0] code);
      logic [3:0] sh;
      sh = (code > TIME_SAT_CODE) ? TIME_SAT_CODE : code;
      return base << sh;
   endfunction

   function automatic logic hit(input logic [6:0] addr, input logic [6:0] ofs);
      return addr == ofs;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Register decode and gain engine.

   always_comb begin
      s_nxt = s_r;
      cin[0] = left_in;
      cin[1] = right_in;
      wr_addr = s_r.shift[15:9];
      wr_data = s_r.shift[8:0];
      // The host frame is shifted on rising port clock edges and accepted on the latch rise.
      s_nxt.clk_d = ctl_clk;
      s_nxt.latch_d = ctl_latch;
      commit = ctl_latch && !s_r.latch_d && (s_r.nbits == FRAME_BITS);
      if (ctl_latch && !s_r.latch_d) begin
         s_nxt.nbits = '0;
      end else if (!ctl_latch && ctl_clk && !s_r.clk_d) begin
         s_nxt.shift = {s_r.shift[14:0], ctl_data};
         if (s_r.nbits != FRAME_BITS) begin
            s_nxt.nbits = s_r.nbits + 5'h01;
         end
      end
      if (commit) begin
         if (hit(wr_addr, OFS_LEFT_GAIN) || hit(wr_addr, OFS_RIGHT_GAIN)) begin
            if (s_r.regs.input_mute[BIT_LINKED_GAIN]) begin
               s_nxt.regs.left_gain = wr_data;
               s_nxt.regs.right_gain = wr_data;
            end else if (hit(wr_addr, OFS_LEFT_GAIN)) begin
               s_nxt.regs.left_gain = wr_data;
            end else begin
               s_nxt.regs.right_gain = wr_data;
            end
         end
         if (hit(wr_addr, OFS_TARGET_CEIL)) s_nxt.regs.target_ceil = wr_data;
         if (hit(wr_addr, OFS_HOLD_ENABLE)) s_nxt.regs.hold_enable = wr_data;
         if (hit(wr_addr, OFS_ATTACK_DECAY)) s_nxt.regs.attack_decay = wr_data;
         if (hit(wr_addr, OFS_NOISE_GATE)) s_nxt.regs.noise_gate = wr_data;
         if (hit(wr_addr, OFS_LIMITER)) s_nxt.regs.limiter = wr_data;
         if (hit(wr_addr, OFS_INPUT_MUTE)) s_nxt.regs.input_mute = wr_data;
         if (hit(wr_addr, OFS_SOFT_RESET)) s_nxt.regs = REGS_RST;
      end

      mode = s_r.regs.target_ceil[8:7];
      auto_mode = (mode != MODE_LIMITER);
      active[0] = s_r.regs.hold_enable[BIT_GAIN_ENABLE] && (mode != MODE_RIGHT);
      active[1] = s_r.regs.hold_enable[BIT_GAIN_ENABLE] && (mode != MODE_LEFT);
      static_g[0] = s_r.regs.left_gain[7:0];
      static_g[1] = s_r.regs.right_gain[7:0];
      tgt = $signed({4'h0, s_r.regs.target_ceil[3:0]}) + TARGET_BASE_DB;
      cc = s_r.regs.noise_gate[4:2];
      thr = $signed({3'h0, cc, 2'b00}) + $signed({4'h0, cc, 1'b0}) + GATE_BASE_DB;
      cc = s_r.regs.target_ceil[6:4];
      fc = s_r.regs.limiter[3:0];
      att = (fc < 4'h3) ? 4'h3 : ((fc > 4'hC) ? 4'hC : fc);
      att2 = {3'h0, att, 1'b0};
      // Hold and window codes are twice as long per code from their first nonzero value.
      hold_c = (s_r.regs.hold_enable[3:0] == 4'h0) ? 32'h0 :
               (32'(HOLD_CYC) << (s_r.regs.hold_enable[3:0] - 4'h1));
      win_c = (s_r.regs.limiter[6:4] == 3'h0) ? 32'h0 :
              (WINDOW_BASE_CYC << (s_r.regs.limiter[6:4] - 3'h1));
      atk_c = auto_mode ? scaled(32'(ATK_AUTO_CYC), s_r.regs.attack_decay[3:0]) :
              scaled(32'(ATK_LIMIT_CYC), s_r.regs.attack_decay[3:0]);
      dcy_c = auto_mode ? scaled(32'(DCY_AUTO_CYC), s_r.regs.attack_decay[7:4]) :
              scaled(32'(DCY_LIMIT_CYC), s_r.regs.attack_decay[7:4]);
      for (int ch = 0; ch < 2; ch++) begin
         if (auto_mode) begin
            ceil_g[ch] = (cc == 3'h0) ? GAIN_ZERO_DB : GAIN_ZERO_DB + {2'b00, cc - 3'h1, 3'b000};
            floor_g[ch] = (fc <= TIME_SAT_CODE) ? GAIN_ZERO_DB - 8'h02 :
                          GAIN_ZERO_DB - 8'h0A - {1'b0, fc - 4'hB, 3'b000};
         end else begin
            ceil_g[ch] = static_g[ch];
            floor_g[ch] = (static_g[ch] > att2) ? static_g[ch] - att2 : 8'h00;
         end
         above[ch] = cin[ch].level_db > tgt;
         gated[ch] = s_r.regs.noise_gate[BIT_GATE_ENABLE] && (cin[ch].level_db < thr);
         // Zero-cross waiting keeps the step pending so no step is lost, only delayed.
         step_ok = !(auto_mode && s_r.regs.hold_enable[BIT_ZERO_CROSS]) || cin[ch].zero_cross;
         if (s_r.timer[ch] != 32'hFFFF_FFFF) begin
            s_nxt.timer[ch] = s_r.timer[ch] + 32'h1;
         end
         if (!active[ch]) begin
            s_nxt.gain[ch] = static_g[ch];
            s_nxt.phase[ch] = PH_IDLE;
            s_nxt.timer[ch] = '0;
         end else if (above[ch]) begin
            case (s_r.phase[ch])
               PH_WINDOW: begin
                  if (s_r.timer[ch] >= win_c) begin
                     s_nxt.phase[ch] = PH_ATTACK;
                     s_nxt.timer[ch] = '0;
                  end
               end
               PH_ATTACK: begin
                  if (s_r.timer[ch] >= atk_c && step_ok && s_r.gain[ch] > floor_g[ch]) begin
                     s_nxt.gain[ch] = s_r.gain[ch] - 8'h01;
                     s_nxt.timer[ch] = '0;
                  end
               end
               default: begin
                  s_nxt.phase[ch] = (!auto_mode && win_c != 32'h0) ? PH_WINDOW : PH_ATTACK;
                  s_nxt.timer[ch] = '0;
               end
            endcase
         end else if (gated[ch]) begin
            s_nxt.phase[ch] = PH_IDLE;
            s_nxt.timer[ch] = '0;
         end else begin
            case (s_r.phase[ch])
               PH_HOLD: begin
                  if (s_r.timer[ch] >= hold_c) begin
                     s_nxt.phase[ch] = PH_DECAY;
                     s_nxt.timer[ch] = '0;
                  end
               end
               PH_DECAY: begin
                  if (s_r.timer[ch] >= dcy_c && step_ok && s_r.gain[ch] < ceil_g[ch]) begin
                     s_nxt.gain[ch] = s_r.gain[ch] + 8'h01;
                     s_nxt.timer[ch] = '0;
                  end
               end
               default: begin
                  s_nxt.phase[ch] = PH_HOLD;
                  s_nxt.timer[ch] = '0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register and outputs.

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_r.regs <= REGS_RST;
         s_r.shift <= '0;
         s_r.nbits <= '0;
         s_r.clk_d <= 1'b0;
         s_r.latch_d <= 1'b0;
         s_r.gain <= {GAIN_ZERO_DB, GAIN_ZERO_DB};
         s_r.timer <= '0;
         s_r.phase <= '{PH_IDLE, PH_IDLE};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign left_gain_value = s_r.gain[0];
   assign right_gain_value = s_r.gain[1];
   assign left_channel_mute = s_r.regs.input_mute[BIT_LEFT_MUTE];
   assign right_channel_mute = s_r.regs.input_mute[BIT_RIGHT_MUTE];
   assign input_pair_select = s_r.regs.input_mute[3:0];
   assign engine_status = '{active, s_r.phase[0], s_r.phase[1]};

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   chk_soft_reset: assert property (@(posedge clk_sys) disable iff (srst)
      commit && wr_addr == OFS_SOFT_RESET |=> s_r.regs == REGS_RST && input_pair_select == 4'h1)
      else $error("soft reset write did not restore registers");

   chk_linked_write: assert property (@(posedge clk_sys) disable iff (srst)
      commit && wr_addr == OFS_LEFT_GAIN && s_r.regs.input_mute[BIT_LINKED_GAIN]
      |=> s_r.regs.right_gain == $past(wr_data) && s_r.regs.left_gain == $past(wr_data))
      else $error("linked gain write missed a channel");

   chk_gain_reset: assert property (@(posedge clk_sys) $fell(srst) |->
      left_gain_value == 8'hCF && right_gain_value == 8'hCF)
      else $error("gain not at 0dB after reset");

   chk_left_mute: assert property (@(posedge clk_sys) disable iff (srst)
      commit && wr_addr == OFS_INPUT_MUTE |=> left_channel_mute == $past(wr_data[7]))
      else $error("left mute does not follow write");

   chk_right_mute: assert property (@(posedge clk_sys) disable iff (srst)
      commit && wr_addr == OFS_INPUT_MUTE |=> right_channel_mute == $past(wr_data[6]))
      else $error("right mute does not follow write");

   chk_engine_off: assert property (@(posedge clk_sys) disable iff (srst)
      !s_r.regs.hold_enable[BIT_GAIN_ENABLE] |=> left_gain_value == $past(s_r.regs.left_gain[7:0]))
      else $error("gain moved while control disabled");

   chk_ceiling_held: assert property (@(posedge clk_sys) disable iff (srst)
      active[0] && auto_mode && s_nxt.gain[0] > s_r.gain[0] |=> left_gain_value <= $past(ceil_g[0]))
      else $error("gain rose above ceiling");

   chk_floor_held: assert property (@(posedge clk_sys) disable iff (srst)
      active[1] && s_nxt.gain[1] < s_r.gain[1] |=> right_gain_value >= $past(floor_g[1]))
      else $error("gain fell below floor");

   chk_gate_holds: assert property (@(posedge clk_sys) disable iff (srst)
      active[0] && gated[0] && !above[0] |=> left_gain_value <= $past(left_gain_value))
      else $error("gain rose under noise gate");

   chk_mode_select: assert property (@(posedge clk_sys) disable iff (srst)
      s_r.regs.hold_enable[BIT_GAIN_ENABLE] && s_r.regs.target_ceil[8:7] == MODE_LEFT
      |-> !active[1] && active[0])
      else $error("mode select enabled wrong channel");

   chk_attack_timing: assert property (@(posedge clk_sys) disable iff (srst)
      active[0] && s_nxt.gain[0] < s_r.gain[0] |-> s_r.phase[0] == PH_ATTACK && s_r.timer[0] >= atk_c)
      else $error("gain fell before attack time");

   chk_decay_timing: assert property (@(posedge clk_sys) disable iff (srst)
      active[1] && s_nxt.gain[1] > s_r.gain[1] |-> s_r.phase[1] == PH_DECAY && s_r.timer[1] >= dcy_c)
      else $error("gain rose before decay time");

   chk_hold_before_rise: assert property (@(posedge clk_sys) disable iff (srst)
      active[1] && s_r.phase[1] == PH_HOLD && s_nxt.phase[1] == PH_DECAY |-> s_r.timer[1] >= hold_c)
      else $error("decay started before hold time");

   chk_window_first: assert property (@(posedge clk_sys) disable iff (srst)
      active[0] && s_r.phase[0] == PH_WINDOW && s_nxt.phase[0] == PH_ATTACK |-> s_r.timer[0] >= win_c)
      else $error("attack started inside transient window");

   chk_zero_cross_gate: assert property (@(posedge clk_sys) disable iff (srst)
      active[0] && auto_mode && s_r.regs.hold_enable[BIT_ZERO_CROSS] && !left_in.zero_cross
      |=> left_gain_value == $past(left_gain_value))
      else $error("gain stepped without zero cross");

   chk_gate_threshold: assert property (@(posedge clk_sys) disable iff (srst)
      thr == GATE_BASE_DB + 8'(6 * s_r.regs.noise_gate[4:2]))
      else $error("gate threshold off its 6dB grid");

   chk_target_level: assert property (@(posedge clk_sys) disable iff (srst)
      tgt == TARGET_BASE_DB + 8'(s_r.regs.target_ceil[3:0]))
      else $error("target level off its 1dB grid");

   chk_limit_floor: assert property (@(posedge clk_sys) disable iff (srst)
      active[0] && !auto_mode && s_nxt.gain[0] < s_r.gain[0]
      |-> {1'b0, s_nxt.gain[0]} + 9'h018 >= {1'b0, static_g[0]})
      else $error("limiter attenuated past its maximum");

   chk_hold_length: assert property (@(posedge clk_sys) disable iff (srst)
      s_r.regs.hold_enable[3:0] == 4'hF |-> hold_c == 32'(HOLD_CYC) * 32'h4000)
      else $error("longest hold time wrong");

   chk_window_length: assert property (@(posedge clk_sys) disable iff (srst)
      s_r.regs.limiter[6:4] == 3'h7 |-> win_c == WINDOW_BASE_CYC * 32'h40)
      else $error("longest transient window wrong");

   chk_attack_sat: assert property (@(posedge clk_sys) disable iff (srst)
      s_r.regs.attack_decay[3:0] >= TIME_SAT_CODE
      |-> atk_c == (auto_mode ? 32'(ATK_AUTO_CYC) : 32'(ATK_LIMIT_CYC)) * 32'h400)
      else $error("attack time not saturated");

   chk_decay_sat: assert property (@(posedge clk_sys) disable iff (srst)
      s_r.regs.attack_decay[7:4] >= TIME_SAT_CODE
      |-> dcy_c == (auto_mode ? 32'(DCY_AUTO_CYC) : 32'(DCY_LIMIT_CYC)) * 32'h400)
      else $error("decay time not saturated");

   chk_ceiling_code: assert property (@(posedge clk_sys) disable iff (srst)
      auto_mode && s_r.regs.target_ceil[6:4] == 3'h7 |-> ceil_g[0] == GAIN_ZERO_DB + 8'h30)
      else $error("top gain ceiling is not 24dB");

endmodule

/* File: bench/ctl_host_model.sv */
// Host controller model that shifts register write frames into the serial control port.
`timescale 1ns/1ps
module ctl_host_model (
   input  wire logic clk_sys,
   output logic      ctl_clk,
   output logic      ctl_data,
   output logic      ctl_latch
);
   initial begin
      ctl_clk   = 1'b0;
      ctl_data  = 1'b0;
      ctl_latch = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Each serial clock half lasts two system cycles so the sampled edge is never missed.
   task automatic write_reg(input logic [6:0] addr, input logic [8:0] data);
      logic [15:0] frame;
      frame = {addr, data};
      @(negedge clk_sys);
      ctl_latch = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         ctl_data = frame[i];
         ctl_clk  = 1'b0;
         repeat (2) @(negedge clk_sys);
         ctl_clk = 1'b1;
         repeat (2) @(negedge clk_sys);
      end
      ctl_clk = 1'b0;
      // The data line no longer carries the last bit once the frame has been shifted.
      ctl_data = ~frame[0];
      @(negedge clk_sys);
      ctl_latch = 1'b1;
      repeat (2) @(negedge clk_sys);
      ctl_latch = 1'b0;
   endtask
endmodule

/* File: bench/adc_level_control_regs_tb.sv */
// Self-checking testbench of the level control registers and gain engine.
`timescale 1ns/1ps
module adc_level_control_regs_tb;
   import level_ctrl_pkg::*;
   localparam int CYC_LIMIT = 6000;
   typedef struct {int kind; logic [7:0] val;} note_s;
   logic       clk_sys;
   logic       srst;
   logic       ctl_clk;
   logic       ctl_data;
   logic       ctl_latch;
   chan_in_s   left_in;
   chan_in_s   right_in;
   logic [7:0] left_gain_value;
   logic [7:0] right_gain_value;
   logic       left_channel_mute;
   logic       right_channel_mute;
   logic [3:0] input_pair_select;
   status_s    engine_status;
   note_s      exp_q[$];
   int         err_count = 0;
   int         compares = 0;
   int         cycles = 0;
   int         seed = 32'h75FA;
   ////////////////////////////////////////////////////////////////////////////////
   adc_level_control_regs #(.HOLD_CYC(4), .ATK_AUTO_CYC(4), .ATK_LIMIT_CYC(4), .DCY_AUTO_CYC(4),
                            .DCY_LIMIT_CYC(4)) adc_level_control_regs_i (
      .clk_sys(clk_sys), .srst(srst), .ctl_clk(ctl_clk), .ctl_data(ctl_data), .ctl_latch(ctl_latch),
      .left_in(left_in), .right_in(right_in), .left_gain_value(left_gain_value),
      .right_gain_value(right_gain_value), .left_channel_mute(left_channel_mute),
      .right_channel_mute(right_channel_mute), .input_pair_select(input_pair_select),
      .engine_status(engine_status));
   ctl_host_model ctl_host_model_i (.clk_sys(clk_sys), .ctl_clk(ctl_clk), .ctl_data(ctl_data),
                                    .ctl_latch(ctl_latch));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic cmp_gain(input string what, input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %0t %s gain got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic cmp_flag(input string what, input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %0t %s got %b expected %b", $time, what, got, exp);
      end
   endtask
   task automatic cmp_field(input string what, input logic [3:0] got, input logic [3:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic note(input int kind, input logic [7:0] val);
      exp_q.push_back('{kind, val});
   endtask
   task automatic check_state(input logic [7:0] lg, input logic [7:0] rg, input logic [1:0] mt,
                              input logic [3:0] pr);
      note(0, lg);
      note(1, rg);
      note(2, {7'h00, mt[1]});
      note(3, {7'h00, mt[0]});
      note(4, {4'h0, pr});
   endtask
   task automatic wr(input logic [6:0] addr, input logic [8:0] data);
      ctl_host_model_i.write_reg(addr, data);
      repeat (4) @(negedge clk_sys);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Reading at the rising edge sees values settled since the previous falling edge.
   always @(posedge clk_sys) begin
      note_s n;
      while (exp_q.size() > 0) begin
         n = exp_q.pop_front();
         case (n.kind)
            0: cmp_gain("left", left_gain_value, n.val);
            1: cmp_gain("right", right_gain_value, n.val);
            2: cmp_flag("left mute", left_channel_mute, n.val[0]);
            3: cmp_flag("right mute", right_channel_mute, n.val[0]);
            4: cmp_field("pair", input_pair_select, n.val[3:0]);
            6: cmp_gain("phase", {2'b00, engine_status.left_phase, engine_status.right_phase}, n.val);
            default: cmp_field("active", {2'b00, engine_status.engine_active}, n.val[3:0]);
         endcase
      end
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == CYC_LIMIT) begin
         err_count++;
         $display("mismatch %0t run did not finish in time", $time);
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] g;
      logic [1:0] mb;
      srst     = 1'b1;
      left_in  = '{8'sh00, 1'b1};
      right_in = '{8'sh00, 1'b1};
      repeat (8) @(negedge clk_sys);
      srst = 1'b0;
      @(negedge clk_sys);
      check_state(RST_GAIN[7:0], RST_GAIN[7:0], 2'b00, RST_INPUT_MUTE[3:0]);
      note(5, 8'h00);
      for (int i = 0; i < 4; i++) begin
         mb = 2'($random(seed));
         wr(OFS_INPUT_MUTE, {1'b0, mb, 2'b00, 4'(1 << i)});
         check_state(RST_GAIN[7:0], RST_GAIN[7:0], mb, 4'(1 << i));
      end
      g = 8'($random(seed));
      wr(OFS_LEFT_GAIN, {1'b0, g});
      wr(OFS_RIGHT_GAIN, {1'b0, ~g});
      // An unmapped offset must leave every register as it was.
      wr(7'h16, 9'h1FF);
      check_state(g, ~g, mb, 4'h8);
      wr(OFS_INPUT_MUTE, 9'h101);
      wr(OFS_LEFT_GAIN, {1'b0, ~g});
      check_state(~g, ~g, 2'b00, 4'h1);
      wr(OFS_SOFT_RESET, 9'($random(seed)));
      check_state(GAIN_ZERO_DB, GAIN_ZERO_DB, 2'b00, 4'h1);
      wr(OFS_TARGET_CEIL, {MODE_STEREO, 7'h7B});
      wr(OFS_HOLD_ENABLE, 9'h100);
      repeat (300) @(negedge clk_sys);
      note(0, GAIN_ZERO_DB - 8'h02);
      note(1, GAIN_ZERO_DB - 8'h02);
      note(5, 8'h03);
      note(6, {2'b00, PH_ATTACK, PH_ATTACK});
      wr(OFS_SOFT_RESET, 9'h000);
      check_state(GAIN_ZERO_DB, GAIN_ZERO_DB, 2'b00, 4'h1);
      left_in.zero_cross  = 1'b0;
      right_in.zero_cross = 1'b0;
      wr(OFS_TARGET_CEIL, {MODE_STEREO, 7'h7B});
      wr(OFS_HOLD_ENABLE, 9'h180);
      repeat (100) @(negedge clk_sys);
      note(0, GAIN_ZERO_DB);
      note(1, GAIN_ZERO_DB);
      left_in.zero_cross  = 1'b1;
      right_in.zero_cross = 1'b1;
      repeat (100) @(negedge clk_sys);
      note(0, GAIN_ZERO_DB - 8'h02);
      note(1, GAIN_ZERO_DB - 8'h02);
      // A quiet left input under the enabled gate must hold while the right one climbs two steps.
      wr(OFS_NOISE_GATE, 9'h01D);
      left_in.level_db  = -8'sh28;
      right_in.level_db = -8'sh14;
      repeat (90) @(negedge clk_sys);
      note(0, GAIN_ZERO_DB - 8'h02);
      note(1, GAIN_ZERO_DB);
      note(6, {2'b00, PH_IDLE, PH_DECAY});
      for (int m = 0; m < 4; m++) begin
         wr(OFS_TARGET_CEIL, {2'(m), 7'h7B});
         note(5, 8'((m == 1) ? 2 : ((m == 2) ? 1 : 3)));
      end
      srst = 1'b1;
      @(negedge clk_sys);
      srst = 1'b0;
      @(negedge clk_sys);
      check_state(RST_GAIN[7:0], RST_GAIN[7:0], 2'b00, RST_INPUT_MUTE[3:0]);
      note(5, 8'h00);
      repeat (2) @(negedge clk_sys);
      stop_test();
   end
endmodule
